// >>> verilog/oft_timer_map.vh
// constants for the overcurrent fault timer
`ifndef OFT_TIMER_MAP_VH
`define OFT_TIMER_MAP_VH
// overload timeout select field, bits 3..2 of the timing register
`define OFT_TOVSEL_MSB 3
`define OFT_TOVSEL_LSB 2
`define OFT_TOVSEL_RESET 2'h0
`define OFT_TOV_60MS 2'h0
`define OFT_TOV_30MS 2'h1
`define OFT_TOV_120MS 2'h2
// times in ms
`define OFT_T60_MS 60
`define OFT_T30_MS 30
`define OFT_T120_MS 120
`define OFT_COOL_MS 1000
// clock rate in kHz and counter tick period in cycles
`define OFT_CLK_KHZ 25000
`define OFT_TICK_CYC 25
// counter increments per ms at one tick per microsecond
`define OFT_TICKS_PER_MS 1000
// decrement runs one sixteenth as fast
`define OFT_DEC_DIV 16
`endif

// >>> verilog/oft_channel.v
// one channel of the overcurrent fault timer
`timescale 1ns/1ns
`include "oft_timer_map.vh"
module oft_channel #(
  parameter CW = 20,
  parameter [CW-1:0] LIM60 = 20'd60000,
  parameter [CW-1:0] LIM30 = 20'd30000,
  parameter [CW-1:0] LIM120 = 20'd120000,
  parameter [CW-1:0] COOLCNT = 20'd1000000
)
(
  input wire clk, // system clock
  input wire sys_rst, // async reset, high
  input wire tick, // counter time base pulse
  input wire [1:0] tovSel, // overload timeout select
  input wire tovChanged, // select field was written with a new value
  input wire startupDone, // start-up window expired
  input wire portOn, // channel currently powered
  input wire overLimit, // current at or above cut limit
  input wire foldback, // current held by foldback
  input wire cutDisable, // cut disable for channel
  input wire cmdOff, // power enable or reset turn-off
  input wire dcDisconnect, // dc disconnect turn-off
  input wire fastShutdown, // fast shutdown input
  input wire resetCmd, // reset command
  input wire offOrManual, // off or manual mode selected
  input wire semiAuto, // semiauto mode
  input wire detectEn, // detect enable bit
  output reg faultCnt_q, // pulse: cut-off fault event
  output reg powerOff_q, // pulse: power channel off
  output reg coolActive_q, // cool-down running, turn-on refused
  output reg startDetect_q, // pulse: start detection
  output reg [CW-1:0] ocCnt_q // overcurrent counter
);
  // ==========================================
  // timeout decode
  reg [CW-1:0] limit;
  always @*
  begin
    case (tovSel)
      `OFT_TOV_60MS: limit = LIM60;
      `OFT_TOV_30MS: limit = LIM30;
      `OFT_TOV_120MS: limit = LIM120;
      default: limit = LIM60;
    endcase
  end
  // ==========================================
  // counter and cool-down
  reg [3:0] decDiv_q;
  reg [CW-1:0] cool_q;
  wire active = startupDone && (overLimit || foldback);
  wire offEvt = cmdOff || dcDisconnect || fastShutdown;
  wire expire = portOn && active && (ocCnt_q + 1'b1 >= limit);
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ocCnt_q <= {CW{1'b0}};
      decDiv_q <= 4'h0;
      cool_q <= {CW{1'b0}};
      coolActive_q <= 1'b0;
      faultCnt_q <= 1'b0;
      powerOff_q <= 1'b0;
      startDetect_q <= 1'b0;
    end
    else
    begin
      powerOff_q <= 1'b0;
      startDetect_q <= 1'b0;
      // one-cycle event, so a later expiry is seen again after a clear
      faultCnt_q <= 1'b0;
      if (offEvt || tovChanged || !portOn)
      begin
        ocCnt_q <= {CW{1'b0}};
        decDiv_q <= 4'h0;
      end
      else if (tick)
      begin
        if (expire)
        begin
          ocCnt_q <= {CW{1'b0}};
          faultCnt_q <= 1'b1;
          if (!cutDisable)
          begin
            powerOff_q <= 1'b1;
            coolActive_q <= 1'b1;
            cool_q <= COOLCNT;
          end
        end
        else if (active)
          ocCnt_q <= ocCnt_q + 1'b1;
        else
        begin
          decDiv_q <= decDiv_q + 4'h1;
          // saturates at zero
          if (decDiv_q == 4'hf && ocCnt_q != {CW{1'b0}})
            ocCnt_q <= ocCnt_q - 1'b1;
        end
      end
      if (coolActive_q)
      begin
        if (resetCmd || offOrManual)
          coolActive_q <= 1'b0;
        else if (tick)
        begin
          if (cool_q <= {{(CW-1){1'b0}}, 1'b1})
          begin
            coolActive_q <= 1'b0;
            startDetect_q <= semiAuto && detectEn;
          end
          cool_q <= cool_q - 1'b1;
        end
      end
    end
  end
endmodule // oft_channel

// >>> verilog/oft_fault_timer.v
// eight-channel overcurrent fault timer
`timescale 1ns/1ns
`include "oft_timer_map.vh"
// Function
// - count up after start-up, while overloaded
// - power off when count reaches timeout
// - one-second cool-down blocks turn-on
// - decrement at sixteenth rate, floor zero
// - clear counter on commanded or fault off
// - timeout field change restarts counter
// - semiauto with detect enable redetects after cool-down
// - reset command or off/manual cancels cool-down
// - cut disable keeps faults, no power-off
// - 00 selects 60 ms, 01 30 ms
module oft_fault_timer #(
  parameter NCH = 8,
  parameter CW = 20,
  parameter TICK_CYC = `OFT_TICK_CYC,
  parameter [CW-1:0] LIM60 = `OFT_T60_MS * `OFT_TICKS_PER_MS,
  parameter [CW-1:0] LIM30 = `OFT_T30_MS * `OFT_TICKS_PER_MS,
  parameter [CW-1:0] LIM120 = `OFT_T120_MS * `OFT_TICKS_PER_MS,
  parameter [CW-1:0] COOLCNT = `OFT_COOL_MS * `OFT_TICKS_PER_MS
)
(
  input wire clk, // 25 MHz clock
  input wire sys_rst, // async reset, high
  input wire tovWrite, // write strobe for timeout select
  input wire [1:0] tovWdata, // new timeout select value
  output wire [1:0] tovSelect, // current timeout select readback
  input wire [NCH-1:0] startupDone, // start-up window expired
  input wire [NCH-1:0] portOn, // channel powered
  input wire [NCH-1:0] overLimit, // current at or above cut limit
  input wire [NCH-1:0] foldback, // current in foldback
  input wire [NCH-1:0] cutDisable, // per-channel cut disable
  input wire [NCH-1:0] cmdOff, // power enable or reset off
  input wire [NCH-1:0] dcDisconnect, // dc disconnect off
  input wire fastShutdown, // fast shutdown input
  input wire [NCH-1:0] resetCmd, // reset command
  input wire [NCH-1:0] offOrManual, // off or manual mode
  input wire [NCH-1:0] semiAuto, // semiauto mode
  input wire [NCH-1:0] detectEn, // detect enable bits
  input wire [NCH-1:0] faultClear, // clear cut-off fault flag
  output reg [NCH-1:0] cutFault, // cut-off fault flags
  output wire [NCH-1:0] powerOff, // pulse: power off channel
  output wire [NCH-1:0] turnOnBlock, // cool-down active
  output wire [NCH-1:0] startDetect // pulse: start detection
);
  // ==========================================
  // timeout select field and time base
  reg [1:0] tovSel_q;
  reg tovChg_q;
  reg [7:0] tickCnt_q;
  wire tick = (tickCnt_q == TICK_CYC - 1);
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tovSel_q <= `OFT_TOVSEL_RESET;
      tovChg_q <= 1'b0;
      tickCnt_q <= 8'h00;
    end
    else
    begin
      tovChg_q <= tovWrite && (tovWdata != tovSel_q);
      if (tovWrite)
        tovSel_q <= tovWdata;
      tickCnt_q <= tick ? 8'h00 : tickCnt_q + 8'h01;
    end
  end
  assign tovSelect = tovSel_q;
  // ==========================================
  // channels
  wire [NCH-1:0] fltEvt;
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1)
    begin : gCh
      oft_channel #(
        .CW(CW), .LIM60(LIM60), .LIM30(LIM30), .LIM120(LIM120), .COOLCNT(COOLCNT)
      ) uCh (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .tovSel(tovSel_q),
        .tovChanged(tovChg_q),
        .startupDone(startupDone[i]),
        .portOn(portOn[i]),
        .overLimit(overLimit[i]),
        .foldback(foldback[i]),
        .cutDisable(cutDisable[i]),
        .cmdOff(cmdOff[i]),
        .dcDisconnect(dcDisconnect[i]),
        .fastShutdown(fastShutdown),
        .resetCmd(resetCmd[i]),
        .offOrManual(offOrManual[i]),
        .semiAuto(semiAuto[i]),
        .detectEn(detectEn[i]),
        .faultCnt_q(fltEvt[i]),
        .powerOff_q(powerOff[i]),
        .coolActive_q(turnOnBlock[i]),
        .startDetect_q(startDetect[i]),
        .ocCnt_q()
      );
    end
  endgenerate
  // ==========================================
  // sticky fault flags; set wins over clear
  reg [NCH-1:0] fltSeen_q;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cutFault <= {NCH{1'b0}};
      fltSeen_q <= {NCH{1'b0}};
    end
    else
    begin
      fltSeen_q <= fltEvt;
      cutFault <= (cutFault & ~faultClear) | (fltEvt & ~fltSeen_q);
    end
  end
endmodule // oft_fault_timer

// >>> tb/oft_checker.sv
// concurrent checks on the fault timer ports
`timescale 1ns/1ns
module oft_checker (
  input wire clk, // clock
  input wire sys_rst, // reset
  input wire tovWrite, // select strobe
  input wire [1:0] tovWdata, // select data
  input wire [1:0] tovSelect, // readback
  input wire [7:0] startupDone, // window over
  input wire [7:0] cutDisable, // cut disable
  input wire [7:0] resetCmd, // reset command
  input wire [7:0] powerOff, // off pulse
  input wire [7:0] turnOnBlock, // cool-down
  input wire [7:0] cutFault, // fault flags
  input wire [7:0] startDetect // redetect pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // expiry steps
  sequence afterOff;
    !powerOff[0] && cutFault[0] && turnOnBlock[0];
  endsequence
  a_sel_write: assert property (tovWrite |=> tovSelect == $past(tovWdata))
    else $error("select readback wrong");
  a_off_steps: assert property (powerOff[0] |=> afterOff)
    else $error("expiry steps wrong");
  a_off_block: assert property (powerOff[0] |-> turnOnBlock[0] && !$past(turnOnBlock[0]))
    else $error("cool-down not started");
  // off pulse follows the expiry tick, so the disable is judged one edge earlier
  a_cut_keep: assert property (cutDisable[0] |=> !powerOff[0])
    else $error("power-off while cut disabled");
  a_cool_cancel: assert property (resetCmd[0] |=> !turnOnBlock[0])
    else $error("cool-down not cancelled");
  a_detect_end: assert property (startDetect[0] |-> !turnOnBlock[0]
    && ($past(turnOnBlock[0]) || $past(turnOnBlock[0], 2)))
    else $error("detect without cool-down end");
  a_detect_pulse: assert property (startDetect[0] |=> !startDetect[0])
    else $error("detect pulse too long");
  a_start_gate: assert property (powerOff[0] |-> $past(startupDone[0]))
    else $error("expiry inside start-up window");
endmodule // oft_checker
bind oft_fault_timer oft_checker chk (.clk, .sys_rst, .tovWrite, .tovWdata, .tovSelect,
  .startupDone, .cutDisable, .resetCmd, .powerOff, .turnOnBlock, .cutFault, .startDetect);

// >>> tb/oft_load_model.sv
// port power and load model facing the fault timer
`timescale 1ns/1ns
module oft_load_model (
  input wire clk, // clock
  input wire sys_rst, // reset
  input wire [7:0] onReq, // host wants port on
  input wire [7:0] loadReq, // heavy load attached
  input wire [7:0] turnOnBlock, // cool-down from device
  input wire [7:0] powerOff, // off pulse from device
  output reg [7:0] portOn_q, // port powered
  output wire [7:0] overLimit // current over cut limit
);
  // an unpowered port draws nothing
  assign overLimit = loadReq & portOn_q;
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      portOn_q <= 8'h00;
    else
      portOn_q <= (portOn_q | (onReq & ~turnOnBlock)) & ~powerOff & onReq;
endmodule // oft_load_model

// >>> tb/overcurrent_fault_timer_test.sv
// self-checking bench for the overcurrent fault timer
`timescale 1ns/1ns
module overcurrent_fault_timer_test;
  reg clk, sys_rst, tovWrite, fastShutdown;
  reg [1:0] tovWdata;
  reg [7:0] startupDone, loadReq, onReq, foldback, cutDisable, cmdOff, dcDisconnect;
  reg [7:0] resetCmd, offOrManual, semiAuto, detectEn, faultClear;
  wire [1:0] tovSelect;
  wire [7:0] portOn, overLimit, cutFault, powerOff, turnOnBlock, startDetect;
  integer num_errors, total_checks, n, k;
  // short counts keep the run small
  oft_fault_timer #(.TICK_CYC(2), .LIM60(20'h14), .LIM30(20'ha), .LIM120(20'h28),
    .COOLCNT(20'h32)) uut (.clk, .sys_rst, .tovWrite, .tovWdata, .tovSelect,
    .startupDone, .portOn, .overLimit, .foldback, .cutDisable, .cmdOff, .dcDisconnect,
    .fastShutdown, .resetCmd, .offOrManual, .semiAuto, .detectEn, .faultClear,
    .cutFault, .powerOff, .turnOnBlock, .startDetect);
  oft_load_model pm (.clk, .sys_rst, .onReq, .loadReq, .turnOnBlock, .powerOff,
    .portOn_q(portOn), .overLimit);
  // ==========
  // checks
  task chk(input [7:0] got, input [7:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task chkRange(input integer got, input integer lo, input integer hi);
  begin
    total_checks = total_checks + 1;
    if (got < lo || got > hi)
    begin
      num_errors = num_errors + 1;
      $display("Error at %0t: took %0d cycles", $time, got);
    end
  end
  endtask
  function pick(input integer s);
    pick = s == 0 ? powerOff[0] : s == 1 ? startDetect[0] : cutFault[0];
  endfunction
  task waitBit(input integer s, input integer lo, input integer hi);
  begin
    n = 0;
    @(negedge clk);
    while (pick(s) !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n = n + 1;
    end
    chkRange(n, lo, hi);
  end
  endtask
  // ==========
  // access tasks
  task wr(input [1:0] v);
  begin
    @(posedge clk);
    tovWrite <= 1'b1;
    tovWdata <= v;
    @(posedge clk);
    tovWrite <= 1'b0;
    // readback settles after the write edge, look at it half a cycle later
    @(negedge clk);
  end
  endtask
  task expire(input integer lim);
  begin
    waitBit(0, 2 * lim - 4, 2 * lim + 4);
    chk(turnOnBlock, 8'h01);
    @(negedge clk);
    chk(cutFault, 8'h01);
  end
  endtask
  task cancel(input m);
  begin
    @(posedge clk);
    if (m)
      resetCmd <= 8'h01;
    else
      offOrManual <= 8'h01;
    @(posedge clk);
    resetCmd <= 8'h00;
    offOrManual <= 8'h00;
    @(negedge clk);
    chk(turnOnBlock, 8'h00);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    end_sim;
  end
  // ==========
  // scenarios
  initial
  begin
    {tovWrite, fastShutdown, tovWdata, startupDone, foldback, cutDisable} = 0;
    {cmdOff, dcDisconnect, resetCmd, offOrManual, semiAuto, detectEn, faultClear} = 0;
    onReq = 8'h03;
    loadReq = 8'h03;
    num_errors = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({6'h00, tovSelect}, 8'h00);
    repeat (60) @(negedge clk);
    chk(turnOnBlock | cutFault, 8'h00);
    @(posedge clk);
    startupDone <= 8'h01;
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(k[1:0]);
      chk({6'h00, tovSelect}, k[7:0]);
      expire(k == 1 ? 10 : k == 2 ? 40 : 20);
      cancel(k[0]);
    end
    wr(2'h1);
    for (k = 0; k < 5; k = k + 1)
    begin
      repeat (16) @(posedge clk);
      case (k)
        0: loadReq <= 8'h00;
        1: cmdOff <= 8'h01;
        2: dcDisconnect <= 8'h01;
        3: fastShutdown <= 1'b1;
        default: tovWdata <= 2'h1;
      endcase
      repeat (k ? 1 : 400) @(posedge clk);
      {cmdOff, dcDisconnect, fastShutdown} <= 0;
      loadReq <= 8'h03;
      if (k == 4)
        wr(2'h0);
      expire(k == 4 ? 20 : 10);
      cancel(1'b1);
    end
    semiAuto <= 8'h01;
    detectEn <= 8'h01;
    expire(20);
    waitBit(1, 96, 106);
    @(posedge clk);
    {semiAuto, loadReq} <= 0;
    {foldback, cutDisable, faultClear} <= {3{8'h01}};
    @(posedge clk);
    faultClear <= 8'h00;
    @(negedge clk);
    chk(cutFault, 8'h00);
    waitBit(2, 30, 48);
    // both ports stay powered and no cool-down runs while cut is disabled
    chk(turnOnBlock | ~portOn, 8'hfc);
    end_sim;
  end
endmodule // overcurrent_fault_timer_test
